// ---- core/link_mode_pkg.sv ----
package link_mode_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_ROUNDTRIP = 8'h3B;
  localparam logic [7:0] ADDR_CTRL_ONE  = 8'h3C;
  localparam logic [7:0] ADDR_CTRL_TWO  = 8'h3D;
  localparam logic [7:0] ADDR_STATE_VEC = 8'h3E;
  localparam logic [7:0] ADDR_DATA      = 8'h3F;
  localparam logic [7:0] ADDR_MODE_CMD  = 8'h40;
  localparam logic [7:0] ADDR_MODE_STAT = 8'h41;

  // ****************************************
  // Reset values and field masks
  // ****************************************
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] MASK_ROUNDTRIP = 8'hCF;
  localparam logic [7:0] MASK_CTRL_ONE  = 8'hF3;
  localparam logic [7:0] MASK_STATE_VEC = 8'h3C;
  localparam int         BIT_WAIT_CLK   = 0;
  localparam int         BIT_IRQ_EN     = 1;
  localparam int         BIT_QUAD_RX    = 5;
  localparam int         BIT_DIG_LOOP   = 6;
  localparam int         BIT_ANA_LOOP   = 7;
  localparam int         BIT_CMD_WAIT   = 0;
  localparam int         BIT_CMD_STOP   = 1;
  localparam int         SV_LSB         = 2;

  // State vector codes
  localparam logic [3:0] SV_IDLE        = 4'h0;
  localparam logic [3:0] SV_WAKE        = 4'h1;
  localparam logic [3:0] SV_EOF         = 4'h2;

  // Idle bus: 300 us at 50 MHz (least time, round up)
  localparam int CLK_MHZ      = 50;
  localparam int IDLE_US      = 300;
  localparam int IDLE_CYCLES  = IDLE_US * CLK_MHZ;
  localparam int IDLE_W       = 16;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    MODE_RESET = 3'b000,
    MODE_RUN   = 3'b001,
    MODE_WAIT  = 3'b011,
    MODE_STOP  = 3'b010,
    MODE_DIG_LOOP = 3'b101,
    MODE_ANA_LOOP = 3'b111,
    MODE_IDLEW = 3'b110
  } mode_type;

  typedef struct packed {
    logic [7:0] adr;
    logic       we;
    logic [7:0] dat;
    logic       sel;
  } bus_req_type;

endpackage

// ---- core/link_mode_ctrl.sv ----
`timescale 1ns/100ps
// How it works
// - Any reset source forces reset mode
// - Reset mode forces registers to reset values
// - Reset mode holds outputs, ignores inputs, but still passes the rx pin to proto_rx_o
// - Run only after all resets release
// - Wait mode returns to run on activity
// - Stop mode returns to run on activity
// - WAIT with select clear enters wait mode
// - Wait: first bus activation raises interrupt
// - Wait: valid end-of-frame raises interrupt
// - STOP, or WAIT with select set, stops
// - Stop halts clocks, watches network
// - Stop activity raises interrupt, restarts clocks
// - Digital loopback ties tx to rx internally
// - Analog loopback leaves digital path unchanged
// - After analog loopback wait for idle bus
// - Roundtrip delay register at 3B
// - Control register one at 3C
// - Control register two at 3D
// - Read-only state vector at 3E
// - Data register at 3F
// - VPW 10.4k, quad 41.6k receive selectable
module link_mode_ctrl
  import link_mode_pkg::*;
(
  // Clock and reset sources
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       low_voltage_reset_i,
  input  wire logic       power_on_reset_i,
  input  wire logic       watchdog_reset_i,
  input  wire logic       reset_pin_i,
  // Wishbone slave
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [7:0] adr_i,
  input  wire logic [7:0] dat_i,
  input  wire logic [0:0] sel_i,
  output logic      [7:0] dat_o,
  output logic            ack_o,
  // Protocol side
  input  wire logic       eof_seen_i,
  input  wire logic       proto_tx_i,
  output logic            proto_rx_o,
  output logic            quad_rx_o,
  output logic            run_clk_en_o,
  output logic            link_active_o,
  output logic            irq_o,
  // Transceiver pins
  input  wire logic       serial_rx_in,
  output logic            serial_tx_out
);

  // ****************************************
  // Reset combine and pin synchroniser
  // ****************************************
  wire        any_rst = rst_i | low_voltage_reset_i | power_on_reset_i
                        | watchdog_reset_i | reset_pin_i;
  logic [1:0] rx_sync_r;
  logic       rx_prev_r;
  logic       tx_r;
  always_ff @(posedge clk_i) begin
    rx_sync_r <= {rx_sync_r[0], serial_rx_in};
    rx_prev_r <= rx_sync_r[1];
  end
  wire rx_s       = rx_sync_r[1];
  wire bus_active = rx_s & ~rx_prev_r;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] rtd_r, cr1_r, cr2_r, data_r;
  logic [3:0] sv_r;
  mode_type   mode_r, mode_nxt;
  logic [IDLE_W-1:0] idle_cnt_r;
  logic       irq_r;

  bus_req_type req;
  assign req = '{adr: adr_i, we: we_i, dat: dat_i, sel: sel_i[0]};
  wire acc  = cyc_i & stb_i & ~ack_o;
  wire wr   = acc & req.we & req.sel;
  wire wr_rtd  = wr & (req.adr == ADDR_ROUNDTRIP);
  wire wr_cr1  = wr & (req.adr == ADDR_CTRL_ONE);
  wire wr_cr2  = wr & (req.adr == ADDR_CTRL_TWO);
  wire wr_data = wr & (req.adr == ADDR_DATA);
  wire wr_cmd  = wr & (req.adr == ADDR_MODE_CMD);

  wire cmd_wait = wr_cmd & req.dat[BIT_CMD_WAIT];
  wire cmd_stop = wr_cmd & req.dat[BIT_CMD_STOP];
  wire wake_ev  = bus_active | ((mode_r == MODE_WAIT) & eof_seen_i);

  // ****************************************
  // Mode machine
  // ****************************************
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_RESET: mode_nxt = MODE_RUN;
      MODE_RUN: begin
        if (cmd_stop || (cmd_wait && cr1_r[BIT_WAIT_CLK]))
          mode_nxt = MODE_STOP;
        else if (cmd_wait)
          mode_nxt = MODE_WAIT;
        else if (cr2_r[BIT_DIG_LOOP])
          mode_nxt = MODE_DIG_LOOP;
        else if (cr2_r[BIT_ANA_LOOP])
          mode_nxt = MODE_ANA_LOOP;
      end
      MODE_WAIT:  if (wake_ev) mode_nxt = MODE_RUN;
      MODE_STOP:  if (bus_active) mode_nxt = MODE_RUN;
      MODE_DIG_LOOP: if (!cr2_r[BIT_DIG_LOOP]) mode_nxt = MODE_RUN;
      MODE_ANA_LOOP: if (!cr2_r[BIT_ANA_LOOP]) mode_nxt = MODE_IDLEW;
      MODE_IDLEW: if (idle_cnt_r == IDLE_W'(IDLE_CYCLES)) mode_nxt = MODE_RUN;
      default:    mode_nxt = MODE_RESET;
    endcase
  end

  // ****************************************
  // Mode and bus answer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      mode_r <= MODE_RESET;
      ack_o  <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      ack_o  <= acc;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  // Reserved bits are cut on the way in, so reads need no mask
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      rtd_r  <= RST_BYTE;
      cr1_r  <= RST_BYTE;
      cr2_r  <= RST_BYTE;
      data_r <= RST_BYTE;
    end else begin
      if (wr_rtd)  rtd_r  <= req.dat & MASK_ROUNDTRIP;
      if (wr_cr1)  cr1_r  <= req.dat & MASK_CTRL_ONE;
      if (wr_cr2)  cr2_r  <= req.dat;
      if (wr_data) data_r <= req.dat;
    end
  end

  // ****************************************
  // Wake flag and state vector
  // ****************************************
  wire in_sleep = (mode_r == MODE_WAIT) || (mode_r == MODE_STOP);
  wire wake_bus = in_sleep & bus_active;
  wire wake_eof = (mode_r == MODE_WAIT) & eof_seen_i;
  wire sv_clear = acc & ~req.we & (req.adr == ADDR_STATE_VEC);

  // Wake events win over a clearing read in the same cycle
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      irq_r <= 1'b0;
      sv_r  <= SV_IDLE;
    end else if (wake_bus) begin
      irq_r <= 1'b1;
      sv_r  <= SV_WAKE;
    end else if (wake_eof) begin
      irq_r <= 1'b1;
      sv_r  <= SV_EOF;
    end else if (sv_clear) begin
      irq_r <= 1'b0;
      sv_r  <= SV_IDLE;
    end
  end

  // ****************************************
  // Idle bus detection
  // ****************************************
  // Any active sample restarts the count, so short gaps never pass
  wire idle_done = (idle_cnt_r == IDLE_W'(IDLE_CYCLES));
  always_ff @(posedge clk_i) begin
    if (any_rst || mode_r != MODE_IDLEW || rx_s)
      idle_cnt_r <= '0;
    else if (!idle_done)
      idle_cnt_r <= idle_cnt_r + IDLE_W'(1);
  end

  // ****************************************
  // Transmit drive and read data
  // ****************************************
  // Analog loopback keeps the digital drive as in run
  wire       tx_live   = (mode_r == MODE_RUN) || (mode_r == MODE_ANA_LOOP);
  wire [7:0] sv_byte   = (8'(sv_r) << SV_LSB) & MASK_STATE_VEC;
  wire [7:0] mode_byte = {5'h00, mode_r};
  wire [7:0] rd_mux    = (req.adr == ADDR_ROUNDTRIP) ? rtd_r     :
                         (req.adr == ADDR_CTRL_ONE)  ? cr1_r     :
                         (req.adr == ADDR_CTRL_TWO)  ? cr2_r     :
                         (req.adr == ADDR_STATE_VEC) ? sv_byte   :
                         (req.adr == ADDR_DATA)      ? data_r    :
                         (req.adr == ADDR_MODE_STAT) ? mode_byte : RST_BYTE;

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      tx_r  <= 1'b0;
      dat_o <= RST_BYTE;
    end else begin
      tx_r  <= tx_live ? proto_tx_i : 1'b0;
      dat_o <= rd_mux;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign serial_tx_out = tx_r;
  // Internal join: frames return without touching the bus
  assign proto_rx_o    = (mode_r == MODE_DIG_LOOP) ? proto_tx_i : rx_s;
  assign quad_rx_o     = cr2_r[BIT_QUAD_RX];
  // Stop gates the protocol clock; wake logic stays live
  assign run_clk_en_o  = (mode_r != MODE_STOP);
  assign link_active_o = (mode_r == MODE_RUN) || (mode_r == MODE_DIG_LOOP)
                         || (mode_r == MODE_ANA_LOOP);
  assign irq_o         = irq_r & cr1_r[BIT_IRQ_EN];

  // ****************************************
  // Checks
  // ****************************************
  property p_reset_mode;
    @(posedge clk_i) any_rst |=> (mode_r == MODE_RESET) && (cr1_r == RST_BYTE);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset not taken");

  property p_run_after;
    @(posedge clk_i) disable iff (any_rst) mode_r == MODE_RESET |=> mode_r == MODE_RUN;
  endproperty
  a_run_after: assert property (p_run_after) else $error("no run after reset");

  property p_wait_enter;
    @(posedge clk_i) disable iff (any_rst)
      mode_r == MODE_RUN && cmd_wait && !cmd_stop && !cr1_r[BIT_WAIT_CLK] |=> mode_r == MODE_WAIT;
  endproperty
  a_wait_enter: assert property (p_wait_enter) else $error("wait not entered");

  property p_stop_enter;
    @(posedge clk_i) disable iff (any_rst)
      mode_r == MODE_RUN && cmd_stop |=> mode_r == MODE_STOP;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop not entered");

  property p_wake_irq;
    @(posedge clk_i) disable iff (any_rst)
      (mode_r == MODE_STOP || mode_r == MODE_WAIT) && bus_active
      |=> irq_r && mode_r == MODE_RUN;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake missed");

  property p_eof_irq;
    @(posedge clk_i) disable iff (any_rst)
      mode_r == MODE_WAIT && eof_seen_i |=> irq_r;
  endproperty
  a_eof_irq: assert property (p_eof_irq) else $error("eof wake missed");

  property p_digital_loopback_select;
    @(posedge clk_i) disable iff (any_rst)
      mode_r == MODE_DIG_LOOP |-> proto_rx_o == proto_tx_i ##1 !serial_tx_out;
  endproperty
  a_digital_loopback_select: assert property (p_digital_loopback_select) else $error("loopback leaks");

  property p_idle_wait;
    @(posedge clk_i) disable iff (any_rst)
      mode_r == MODE_ANA_LOOP && !cr2_r[BIT_ANA_LOOP] |=> mode_r == MODE_IDLEW ##1 !link_active_o;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("idle wait skipped");

  property p_stop_clk;
    @(posedge clk_i) disable iff (any_rst) mode_r == MODE_STOP |-> !run_clk_en_o;
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("clock runs in stop");

  property p_regs_reset;
    @(posedge clk_i)
      any_rst |=> rtd_r == RST_BYTE && cr2_r == RST_BYTE && data_r == RST_BYTE;
  endproperty
  a_regs_reset: assert property (p_regs_reset) else $error("registers not reset");

  property p_flag_reset;
    @(posedge clk_i)
      any_rst |=> !irq_o && !ack_o && sv_r == SV_IDLE;
  endproperty
  a_flag_reset: assert property (p_flag_reset) else $error("flags not reset");

  property p_tx_reset;
    @(posedge clk_i)
      any_rst |=> !serial_tx_out;
  endproperty
  a_tx_reset: assert property (p_tx_reset) else $error("tx driven in reset");

  property p_reset_idle;
    @(posedge clk_i)
      mode_r == MODE_RESET |-> !link_active_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("active in reset");

  property p_rtd_reserved;
    @(posedge clk_i) disable iff (any_rst)
      (rtd_r & ~MASK_ROUNDTRIP) == RST_BYTE;
  endproperty
  a_rtd_reserved: assert property (p_rtd_reserved) else $error("reserved bits set");

  property p_cr1_reserved;
    @(posedge clk_i) disable iff (any_rst)
      (cr1_r & ~MASK_CTRL_ONE) == RST_BYTE;
  endproperty
  a_cr1_reserved: assert property (p_cr1_reserved) else $error("reserved bits set");

  property p_cr2_write;
    @(posedge clk_i) disable iff (any_rst)
      wr_cr2 |=> cr2_r == $past(req.dat);
  endproperty
  a_cr2_write: assert property (p_cr2_write) else $error("control two not written");

  property p_sv_reserved;
    @(posedge clk_i) disable iff (any_rst)
      sv_clear |=> (dat_o & ~MASK_STATE_VEC) == RST_BYTE;
  endproperty
  a_sv_reserved: assert property (p_sv_reserved) else $error("state byte reserved bits");

  property p_sv_ro;
    @(posedge clk_i) disable iff (any_rst)
      wr && req.adr == ADDR_STATE_VEC && !wake_bus && !wake_eof |=> $stable(sv_r);
  endproperty
  a_sv_ro: assert property (p_sv_ro) else $error("state vector written");

  property p_data_write;
    @(posedge clk_i) disable iff (any_rst)
      wr_data |=> data_r == $past(req.dat);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data not written");

  property p_quad;
    @(posedge clk_i) disable iff (any_rst)
      wr_cr2 |=> quad_rx_o == $past(req.dat[BIT_QUAD_RX]);
  endproperty
  a_quad: assert property (p_quad) else $error("quad receive not set");

  property p_stop_wake;
    @(posedge clk_i) disable iff (any_rst)
      mode_r == MODE_STOP && bus_active |=> run_clk_en_o;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("clock not restarted");

  property p_wait_run;
    @(posedge clk_i) disable iff (any_rst)
      mode_r == MODE_WAIT && eof_seen_i |=> mode_r == MODE_RUN;
  endproperty
  a_wait_run: assert property (p_wait_run) else $error("wait not left");

  property p_wait_clk;
    @(posedge clk_i) disable iff (any_rst)
      mode_r == MODE_WAIT |-> run_clk_en_o;
  endproperty
  a_wait_clk: assert property (p_wait_clk) else $error("clock stopped in wait");

  property p_ana_tx;
    @(posedge clk_i) disable iff (any_rst)
      mode_r == MODE_ANA_LOOP |=> serial_tx_out == $past(proto_tx_i);
  endproperty
  a_ana_tx: assert property (p_ana_tx) else $error("analog loop tx changed");

  property p_dig_enter;
    @(posedge clk_i) disable iff (any_rst)
      mode_r == MODE_RUN && cr2_r[BIT_DIG_LOOP] && !cmd_wait && !cmd_stop
      |=> mode_r == MODE_DIG_LOOP;
  endproperty
  a_dig_enter: assert property (p_dig_enter) else $error("loopback not entered");

  c_wait: cover property (@(posedge clk_i) mode_r == MODE_WAIT ##1 mode_r == MODE_RUN);
  c_stop: cover property (@(posedge clk_i) mode_r == MODE_STOP ##1 mode_r == MODE_RUN);
  c_eof:  cover property (@(posedge clk_i) wake_eof);
  c_dl:   cover property (@(posedge clk_i) mode_r == MODE_DIG_LOOP);
  c_al:   cover property (@(posedge clk_i) mode_r == MODE_IDLEW ##1 mode_r == MODE_RUN);

endmodule

// ---- testbench/xcvr_model.sv ----
`timescale 1ns/100ps
// ************************
// Off-chip transceiver
// ************************
module xcvr_model (
  // Bench control
  input  wire logic loop_i,
  input  wire logic act_i,
  // Link pins
  input  wire logic tx_i,
  output logic      rx_o
);
  // Echo happens here, the controller path stays as in run
  assign rx_o = loop_i ? tx_i : act_i;
endmodule

// ---- testbench/vpw_link_controller_modes_test.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module vpw_link_controller_modes_test;
  import link_mode_pkg::*;
  // ************************
  // Stimulus and wiring
  // ************************
  logic       clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic       eof_seen_i = 0, proto_tx_i = 0, loop = 0, act = 0;
  logic [3:0] rsrc = 0;
  logic [7:0] adr_i = 0, dat_i = 0, q, v;
  logic [0:0] sel_i = 0;
  logic [7:0] al [6] = '{8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h5A};
  logic [31:0] seed = 32'he180_7e9f;
  mode_type   m;
  wire logic [7:0] dat_o;
  wire logic  ack_o, proto_rx_o, quad_rx_o, run_clk_en_o, link_active_o, irq_o, rx, tx;
  int         err_total = 0, n_compared = 0, cyc_cnt = 0;
  always #10 clk_i = ~clk_i;
  link_mode_ctrl DUT (.clk_i, .rst_i, .low_voltage_reset_i(rsrc[0]),
    .power_on_reset_i(rsrc[1]), .watchdog_reset_i(rsrc[2]), .reset_pin_i(rsrc[3]),
    .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o, .eof_seen_i,
    .proto_tx_i, .proto_rx_o, .quad_rx_o, .run_clk_en_o, .link_active_o, .irq_o,
    .serial_rx_in(rx), .serial_tx_out(tx));
  xcvr_model PART (.loop_i(loop), .act_i(act), .tx_i(tx), .rx_o(rx));
  // ************************
  // Helpers
  // ************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] d);
    case (a)
      ADDR_ROUNDTRIP: return d & MASK_ROUNDTRIP;
      ADDR_CTRL_ONE: return d & MASK_CTRL_ONE;
      ADDR_CTRL_TWO, ADDR_DATA: return d;
      default: return 8'h00;
    endcase
  endfunction
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    cyc_i <= 1; stb_i <= 1; adr_i <= a; we_i <= w; dat_i <= d; sel_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) err_total++;
    q = dat_o;
    cyc_i <= 0; stb_i <= 0; sel_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic chk_mode(input mode_type e);
    wb(ADDR_MODE_STAT, 0, 0);
    `CHK("mode", e, q[2:0])
  endtask
  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Ceiling well above the idle wait plus the rest
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      err_total++;
      end_sim;
    end
  end
  // ************************
  // Scenarios
  // ************************
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    repeat (2) @(posedge clk_i);
    chk_mode(MODE_RUN);
    for (int i = 0; i < 6; i++) begin
      wb(al[i], 0, 0);
      `CHK("reset value", RST_BYTE, q)
    end
    repeat (12) for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      v = (al[i] == ADDR_CTRL_TWO) ? (seed[7:0] & 8'h3F) : seed[7:0];
      proto_tx_i <= seed[9];
      wb(al[i], 1, v);
      wb(al[i], 0, 0);
      `CHK("readback", exp_rd(al[i], v), q)
      if (al[i] == ADDR_CTRL_TWO) `CHK("quad rx", v[5], quad_rx_o)
    end
    wb(ADDR_CTRL_TWO, 1, 8'h40);
    chk_mode(MODE_DIG_LOOP);
    repeat (6) begin
      seed = lfsr(seed);
      proto_tx_i <= seed[0];
      @(negedge clk_i);
      `CHK("loop rx", proto_tx_i, proto_rx_o)
      `CHK("loop tx", 1'b0, tx)
      @(posedge clk_i);
    end
    wb(ADDR_CTRL_TWO, 1, 8'h00);
    chk_mode(MODE_RUN);
    for (int k = 0; k < 4; k++) begin
      // Bench never leaves run with a frame in flight
      wb(ADDR_CTRL_ONE, 1, (k == 1) ? 8'h03 : 8'h02);
      wb(ADDR_MODE_CMD, 1, (k == 2) ? 8'h02 : 8'h01);
      m = (k == 1 || k == 2) ? MODE_STOP : MODE_WAIT;
      chk_mode(m);
      `CHK("clk en", m != MODE_STOP, run_clk_en_o)
      if (k == 3) eof_seen_i <= 1;
      else act <= 1;
      @(posedge clk_i);
      eof_seen_i <= 0;
      repeat (6) @(posedge clk_i);
      act <= 0;
      `CHK("irq", 1'b1, irq_o)
      `CHK("clk en", 1'b1, run_clk_en_o)
      chk_mode(MODE_RUN);
      wb(ADDR_STATE_VEC, 0, 0);
      `CHK("wake code", (k == 3) ? 8'h08 : 8'h04, q)
      wb(ADDR_STATE_VEC, 0, 0);
      `CHK("code cleared", 8'h00, q)
      `CHK("irq cleared", 1'b0, irq_o)
    end
    for (int s = 0; s < 5; s++) begin
      wb(ADDR_CTRL_ONE, 1, 8'hF3);
      proto_tx_i <= 1;
      if (s == 4) rst_i <= 1;
      else rsrc[s] <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("reset active", 1'b0, link_active_o)
      `CHK("reset tx", 1'b0, tx)
      rsrc <= 0; rst_i <= 0;
      repeat (2) @(posedge clk_i);
      wb(ADDR_CTRL_ONE, 0, 0);
      `CHK("reg after reset", RST_BYTE, q)
      chk_mode(MODE_RUN);
    end
    wb(ADDR_CTRL_TWO, 1, 8'h80);
    chk_mode(MODE_ANA_LOOP);
    loop <= 1;
    repeat (8) @(posedge clk_i);
    `CHK("echo tx", 1'b1, tx)
    `CHK("echo rx", 1'b1, proto_rx_o)
    loop <= 0; proto_tx_i <= 0;
    wb(ADDR_CTRL_TWO, 1, 8'h00);
    chk_mode(MODE_IDLEW);
    repeat (IDLE_CYCLES - 100) @(posedge clk_i);
    chk_mode(MODE_IDLEW);
    repeat (200) @(posedge clk_i);
    chk_mode(MODE_RUN);
    end_sim;
  end
endmodule
